//--- design/motion_cmd_pkg.sv
/*
 * constants, register map and carrier types for the motion command port.
 * assumes a 10 MHz aclk and an axi4-lite master with 32-bit data.
 */
package motion_cmd_pkg;

  // ****************************************************
  // command codes
  // ****************************************************
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] LOAD_POSITION_CODE = 8'h01;
  localparam logic [7:0] SET_RATE_CODE = 8'h02;
  localparam logic [7:0] CLEAR_PULSE_CODE = 8'h03;
  localparam logic [7:0] CONFIG_RELOAD_CODE = 8'h04;

  // ****************************************************
  // result codes
  // ****************************************************
  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_ABORTED = 8'h01;
  localparam logic [7:0] RES_ILLEGAL = 8'h03;
  localparam logic [7:0] RES_NO_REF = 8'h06;

  // ****************************************************
  // register byte offsets
  // ****************************************************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_NEW_POS = 8'h08;
  localparam logic [7:0] OFS_CUR_POS = 8'h0c;
  localparam logic [7:0] OFS_ACCEL = 8'h10;
  localparam logic [7:0] OFS_DECEL = 8'h14;
  localparam logic [7:0] OFS_JERK = 8'h18;
  localparam logic [7:0] OFS_INHIBIT = 8'h1c;
  localparam logic [7:0] OFS_CFG_PTR = 8'h20;
  localparam logic [7:0] OFS_CFG_WORD = 8'h24;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
  localparam logic [7:0] OFS_CFG_LIVE = 8'h30;
  localparam logic [7:0] OFS_RATES_APPLIED = 8'h34;

  // field positions
  localparam int CMD_START_BIT = 8;
  localparam int CMD_ABORT_BIT = 9;
  localparam int INHIBIT_EN_BIT = 8;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_RESULT_LSB = 8;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;

  // reset values and response codes
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int CLEAR_PULSE_MS = 50;
  localparam int CLEAR_PULSE_CYC = CLEAR_PULSE_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {ST_IDLE, ST_CLEAR, ST_CFG} cmd_state_e;

  typedef struct packed {
    logic done;
    logic busy;
    logic [7:0] result;
  } cmd_status_s;

  typedef struct packed {
    logic [31:0] accel;
    logic [31:0] decel;
    logic [31:0] jerk;
  } rate_set_s;

endpackage

//--- design/motion_cmd_port.sv
/*
 * command interpreter of the motion module: takes start/command requests
 * from the host over axi4-lite, runs position load, rate set, clear pulse
 * and configuration reload, reports done/busy/result and current position.
 * assumes one clock aclk at 10 MHz, a synchronous active-low reset and a
 * master with at most one write and one read outstanding. the config block
 * lives in a small host-side table that the host fills through CFG_WORD.
 */
`timescale 1ns/100ps
module motion_cmd_port #(
  parameter int CLEAR_CYC = motion_cmd_pkg::CLEAR_PULSE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic drive_inhibit_output,
  output logic clear_pulse_output,
  output logic irq
);

  localparam int CFG_WORDS = 8;

  // ****************************************************
  // state
  // ****************************************************
  logic [31:0] cur_pos_r;
  logic [31:0] new_pos_r;
  motion_cmd_pkg::rate_set_s rate_tab_r;
  motion_cmd_pkg::rate_set_s rate_live_r;
  logic [7:0] cmd_code_r;
  logic [7:0] inhibit_r;
  logic [4:0] cfg_ptr_r;
  logic [31:0] host_cfg_r [0:2*CFG_WORDS-1];
  logic [31:0] cfg_live_r [0:CFG_WORDS-1];
  logic [7:0] cfg_changes_r;
  logic [2:0] cfg_idx_r;
  motion_cmd_pkg::cmd_status_s st_r;
  motion_cmd_pkg::cmd_state_e state_r;
  logic [31:0] clr_cnt_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [7:0] awaddr_r;
  logic aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_held_r;

  // ****************************************************
  // write channel capture, either order
  // ****************************************************
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && s_axi_arready;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  wire [31:0] wmerged_cmd = merge({24'h000000, cmd_code_r}, wdata_r, wstrb_r);
  wire hit_cmd = wr_go && awaddr_r == motion_cmd_pkg::OFS_CMD;
  wire start_req = hit_cmd && wmerged_cmd[motion_cmd_pkg::CMD_START_BIT];
  wire abort_req = hit_cmd && wmerged_cmd[motion_cmd_pkg::CMD_ABORT_BIT];
  wire [7:0] req_code = wmerged_cmd[7:0];
  wire idle = state_r == motion_cmd_pkg::ST_IDLE;
  // a start while busy is dropped; the host retries next scan
  wire accept = start_req && idle;
  wire code_known = req_code == motion_cmd_pkg::LOAD_POSITION_CODE
                 || req_code == motion_cmd_pkg::SET_RATE_CODE
                 || req_code == motion_cmd_pkg::CLEAR_PULSE_CODE
                 || req_code == motion_cmd_pkg::CONFIG_RELOAD_CODE;
  wire inst_done = accept && (req_code == motion_cmd_pkg::LOAD_POSITION_CODE
                 || req_code == motion_cmd_pkg::SET_RATE_CODE || !code_known);
  wire clr_end = state_r == motion_cmd_pkg::ST_CLEAR && clr_cnt_r == 32'h0000_0001;
  wire cfg_end = state_r == motion_cmd_pkg::ST_CFG && cfg_idx_r == 3'h7;
  wire ab_now = abort_req && !idle;
  wire fin = inst_done || clr_end || cfg_end || ab_now;
  wire [7:0] fin_res = ab_now ? motion_cmd_pkg::RES_ABORTED :
                       (inst_done && !code_known) ? motion_cmd_pkg::RES_ILLEGAL :
                       motion_cmd_pkg::RES_OK;
  // the fetch index wraps at the end of the host table
  wire [3:0] cfg_sel = cfg_ptr_r[3:0] + {1'b0, cfg_idx_r};
  wire [31:0] cfg_new = host_cfg_r[cfg_sel];
  wire cfg_diff = cfg_new != cfg_live_r[cfg_idx_r];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= motion_cmd_pkg::RST_ZERO;
      wstrb_r <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  wire mapped_wr = awaddr_r[1:0] == 2'b00 && (awaddr_r <= motion_cmd_pkg::OFS_IRQ_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= motion_cmd_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_r && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !w_take && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped_wr ? motion_cmd_pkg::RESP_OKAY : motion_cmd_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************
  // register writes
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      new_pos_r <= motion_cmd_pkg::RST_ZERO;
      rate_tab_r <= '0;
      inhibit_r <= 8'h00;
      cfg_ptr_r <= 5'h00;
      irq_mask_r <= 2'b00;
      cmd_code_r <= motion_cmd_pkg::CMD_NONE;
    end else if (wr_go) begin
      if (awaddr_r == motion_cmd_pkg::OFS_CMD) begin
        cmd_code_r <= req_code;
      end else if (awaddr_r == motion_cmd_pkg::OFS_NEW_POS) begin
        new_pos_r <= merge(new_pos_r, wdata_r, wstrb_r);
      end else if (awaddr_r == motion_cmd_pkg::OFS_ACCEL) begin
        rate_tab_r.accel <= merge(rate_tab_r.accel, wdata_r, wstrb_r);
      end else if (awaddr_r == motion_cmd_pkg::OFS_DECEL) begin
        rate_tab_r.decel <= merge(rate_tab_r.decel, wdata_r, wstrb_r);
      end else if (awaddr_r == motion_cmd_pkg::OFS_JERK) begin
        rate_tab_r.jerk <= merge(rate_tab_r.jerk, wdata_r, wstrb_r);
      end else if (awaddr_r == motion_cmd_pkg::OFS_INHIBIT) begin
        inhibit_r <= wstrb_r[1] ? wdata_r[15:8] : inhibit_r;
        if (wstrb_r[0]) begin
          inhibit_r <= {7'h00, wdata_r[motion_cmd_pkg::INHIBIT_EN_BIT] && wstrb_r[1]
                        ? |wdata_r[7:0] : drive_inhibit_output};
        end
      end else if (awaddr_r == motion_cmd_pkg::OFS_CFG_PTR) begin
        cfg_ptr_r <= {1'b0, wdata_r[3:0]};
      end else if (awaddr_r == motion_cmd_pkg::OFS_IRQ_MASK) begin
        irq_mask_r <= wdata_r[1:0];
      end
    end
  end

  // host-side configuration table, written as words indexed by data bits 27:24
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2 * CFG_WORDS; i++) host_cfg_r[i] <= motion_cmd_pkg::RST_ZERO;
    end else if (wr_go && awaddr_r == motion_cmd_pkg::OFS_CFG_WORD) begin
      host_cfg_r[wdata_r[27:24]] <= {8'h00, wdata_r[23:0]};
    end
  end

  // ****************************************************
  // command engine
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= motion_cmd_pkg::ST_IDLE;
      st_r <= '0;
      cur_pos_r <= motion_cmd_pkg::RST_ZERO;
      rate_live_r <= '0;
      clr_cnt_r <= motion_cmd_pkg::RST_ZERO;
      clear_pulse_output <= 1'b0;
      cfg_idx_r <= 3'h0;
      cfg_changes_r <= 8'h00;
    end else begin
      if (accept) begin
        st_r.done <= 1'b0;
        st_r.busy <= 1'b1;
        cfg_idx_r <= 3'h0;
        case (req_code)
          motion_cmd_pkg::LOAD_POSITION_CODE: cur_pos_r <= new_pos_r;
          motion_cmd_pkg::SET_RATE_CODE: rate_live_r <= rate_tab_r;
          motion_cmd_pkg::CLEAR_PULSE_CODE: begin
            state_r <= motion_cmd_pkg::ST_CLEAR;
            clr_cnt_r <= CLEAR_CYC;
            clear_pulse_output <= 1'b1;
          end
          motion_cmd_pkg::CONFIG_RELOAD_CODE: begin
            state_r <= motion_cmd_pkg::ST_CFG;
            cfg_changes_r <= 8'h00;
          end
          default: state_r <= motion_cmd_pkg::ST_IDLE;
        endcase
      end
      case (state_r)
        motion_cmd_pkg::ST_CLEAR: clr_cnt_r <= clr_cnt_r - 32'h0000_0001;
        motion_cmd_pkg::ST_CFG: begin
          cfg_idx_r <= cfg_idx_r + 3'h1;
          if (cfg_diff) begin
            cfg_changes_r <= cfg_changes_r + 8'h01;
          end
        end
        default: ;
      endcase
      if (fin) begin
        state_r <= motion_cmd_pkg::ST_IDLE;
        st_r.done <= 1'b1;
        st_r.busy <= 1'b0;
        st_r.result <= fin_res;
        clear_pulse_output <= 1'b0;
      end
    end
  end

  // only differing words are rewritten
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < CFG_WORDS; i++) cfg_live_r[i] <= motion_cmd_pkg::RST_ZERO;
    end else if (state_r == motion_cmd_pkg::ST_CFG && cfg_diff) begin
      cfg_live_r[cfg_idx_r] <= cfg_new;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_inhibit_output <= 1'b0;
    end else begin
      drive_inhibit_output <= inhibit_r[0];
    end
  end

  // ****************************************************
  // interrupts
  // ****************************************************
  wire w1c = wr_go && awaddr_r == motion_cmd_pkg::OFS_IRQ_STAT;
  wire [1:0] irq_set = {fin && fin_res != motion_cmd_pkg::RES_OK, fin};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= 2'b00;
      irq <= 1'b0;
    end else begin
      // a new event wins over a same-cycle clear
      irq_stat_r <= (irq_stat_r & ~(w1c ? wdata_r[1:0] : 2'b00)) | irq_set;
      irq <= |(((irq_stat_r & ~(w1c ? wdata_r[1:0] : 2'b00)) | irq_set) & irq_mask_r);
    end
  end

  // ****************************************************
  // read channel
  // ****************************************************
  wire [7:0] ra = s_axi_araddr;
  wire [31:0] rd_val =
    (ra == motion_cmd_pkg::OFS_CMD) ? {24'h000000, cmd_code_r} :
    (ra == motion_cmd_pkg::OFS_STATUS) ? {16'h0000, st_r.result, 6'h00, st_r.busy, st_r.done} :
    (ra == motion_cmd_pkg::OFS_NEW_POS) ? new_pos_r :
    (ra == motion_cmd_pkg::OFS_CUR_POS) ? cur_pos_r :
    (ra == motion_cmd_pkg::OFS_ACCEL) ? rate_live_r.accel :
    (ra == motion_cmd_pkg::OFS_DECEL) ? rate_live_r.decel :
    (ra == motion_cmd_pkg::OFS_JERK) ? rate_live_r.jerk :
    (ra == motion_cmd_pkg::OFS_INHIBIT) ? {31'h00000000, drive_inhibit_output} :
    (ra == motion_cmd_pkg::OFS_CFG_PTR) ? {27'h0000000, cfg_ptr_r} :
    (ra == motion_cmd_pkg::OFS_IRQ_STAT) ? {30'h00000000, irq_stat_r} :
    (ra == motion_cmd_pkg::OFS_IRQ_MASK) ? {30'h00000000, irq_mask_r} :
    (ra == motion_cmd_pkg::OFS_CFG_LIVE) ? {24'h000000, cfg_changes_r} :
    motion_cmd_pkg::RST_ZERO;
  wire rd_ok = ra[1:0] == 2'b00 && ra <= motion_cmd_pkg::OFS_CFG_LIVE
               && ra != motion_cmd_pkg::OFS_CFG_WORD;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= motion_cmd_pkg::RST_ZERO;
      s_axi_rresp <= motion_cmd_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? motion_cmd_pkg::RESP_OKAY : motion_cmd_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

//--- verif/motion_cmd_chk.sv
/* checker for the motion command port: bus answers, clear pulse length
   and inhibit level. assumes it is bound to motion_cmd_port, one aclk. */
`timescale 1ns/100ps
module motion_cmd_chk #(
  parameter int CLEAR_CYC = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic drive_inhibit_output,
  input wire logic clear_pulse_output,
  input wire logic irq
);
  // *****
  // helpers
  // *****
  logic [31:0] hi_r;
  logic [31:0] hi_nxt;
  logic abort_r;
  logic abort_nxt;
  logic abort_wr;
  // an abort may cut the pulse short, so only full pulses get the exact-length check
  assign abort_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                    && s_axi_awaddr == motion_cmd_pkg::OFS_CMD
                    && s_axi_wdata[motion_cmd_pkg::CMD_ABORT_BIT];
  assign abort_nxt = abort_wr || (abort_r && clear_pulse_output);
  assign hi_nxt = clear_pulse_output ? hi_r + 32'h1 : 32'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_r <= 32'h0;
      abort_r <= 1'b0;
    end else begin
      hi_r <= hi_nxt;
      abort_r <= abort_nxt;
    end
  end
  // *****
  // properties
  // *****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_inh;
    s_wr ##0 (s_axi_awaddr == motion_cmd_pkg::OFS_INHIBIT && s_axi_wdata[8]);
  endsequence
  property p_b_follows; s_wr |-> ##[1:3] s_axi_bvalid; endproperty
  property p_r_follows; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_busy_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_clr_max; clear_pulse_output |-> hi_r < CLEAR_CYC; endproperty
  property p_clr_full; $fell(clear_pulse_output) && !abort_r |-> hi_r == CLEAR_CYC;
  endproperty
  property p_inh_on; s_inh ##0 (|s_axi_wdata[7:0]) |-> ##[1:4] drive_inhibit_output;
  endproperty
  property p_inh_off; s_inh ##0 !(|s_axi_wdata[7:0]) |-> ##[1:4] !drive_inhibit_output;
  endproperty
  a_b_follows: assert property (p_b_follows) else $error("write not answered");
  a_r_follows: assert property (p_r_follows) else $error("read not answered");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_r_hold: assert property (p_r_hold) else $error("read answer changed");
  a_busy_refuse: assert property (p_busy_refuse) else $error("write taken early");
  a_clr_max: assert property (p_clr_max) else $error("clear pulse too long");
  a_clr_full: assert property (p_clr_full) else $error("clear pulse length");
  a_inh_on: assert property (p_inh_on) else $error("inhibit not set");
  a_inh_off: assert property (p_inh_off) else $error("inhibit not cleared");
endmodule

bind motion_cmd_port motion_cmd_chk #(.CLEAR_CYC(CLEAR_CYC)) u_chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .drive_inhibit_output, .clear_pulse_output, .irq);

//--- verif/host_model.sv
/* host model: axi4-lite master, one write and one read at a time.
   assumes the bench calls wr and rd and shares aclk with the port. */
`timescale 1ns/100ps
module host_model (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp
);
  logic ta, tw, tb, seen;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
  end
  // *****
  // requests
  // *****
  // ready is sampled mid-cycle so the release lands right after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic slow,
                    output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slow;
    forever begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      seen = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (tb) begin
        s_axi_bready <= 1'b0;
        break;
      end else if (seen) begin
        s_axi_bready <= 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic slow);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow;
    forever begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tb = s_axi_rvalid && s_axi_rready;
      seen = s_axi_rvalid;
      @(posedge aclk);
      if (ta) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (tb) begin
        s_axi_rready <= 1'b0;
        break;
      end else if (seen) begin
        s_axi_rready <= 1'b1;
      end
    end
  endtask
endmodule

//--- verif/motion_cmd_port_tb.sv
/* self-checking bench for the motion command port.
   assumes the host model drives the bus and the checker is bound in. */
`timescale 1ns/100ps
module motion_cmd_port_tb;
  localparam int CYC = 20;
  typedef struct packed {logic [31:0] v; logic [31:0] m; logic [1:0] r;} note_s;
  logic aclk, aresetn, irq, drive_inhibit_output, clear_pulse_output;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, w;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] rate [3];
  note_s notes [$];
  note_s n;
  integer seed, n_fail, total_checks;
  motion_cmd_port #(.CLEAR_CYC(CYC)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .drive_inhibit_output, .clear_pulse_output, .irq);
  host_model host (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // *****
  // tasks
  // *****
  function automatic logic coin();
    coin = ($random(seed) & 1) != 0;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = motion_cmd_pkg::RESP_OKAY);
    logic [1:0] r;
    host.wr(a, d, coin(), r);
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
                    input logic [1:0] er = motion_cmd_pkg::RESP_OKAY);
    notes.push_back('{e, m, er});
    host.rd(a, coin());
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(motion_cmd_pkg::OFS_CMD, {23'h0, 1'b1, c});
  endtask
  task automatic wait_clear();
    for (int k = 0; k < CYC + 20 && clear_pulse_output; k++) @(posedge aclk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // a read answer is compared mid-cycle, before the taking edge
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      n = notes.pop_front();
      chk("rdata", s_axi_rdata & n.m, n.v & n.m);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, n.r});
    end
  end
  initial begin
    repeat (4000) @(posedge aclk);
    n_fail++;
    give_verdict();
  end
  // *****
  // scenarios
  // *****
  initial begin
    {aresetn, n_fail, total_checks} = '0;
    seed = 32'hd90e5284;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(motion_cmd_pkg::OFS_CUR_POS, 32'h0);
    for (int i = 0; i < 2; i++) begin
      v = $random(seed);
      wr(motion_cmd_pkg::OFS_NEW_POS, v);
      cmd(motion_cmd_pkg::LOAD_POSITION_CODE);
      rd(motion_cmd_pkg::OFS_STATUS, 32'h1);
      rd(motion_cmd_pkg::OFS_CUR_POS, v);
    end
    $display("test load position done");
    for (int i = 0; i < 3; i++) begin
      rate[i] = $random(seed);
      wr(motion_cmd_pkg::OFS_ACCEL + 8'(4 * i), rate[i]);
    end
    rd(motion_cmd_pkg::OFS_ACCEL, 32'h0);
    cmd(motion_cmd_pkg::SET_RATE_CODE);
    for (int i = 0; i < 3; i++) rd(motion_cmd_pkg::OFS_ACCEL + 8'(4 * i), rate[i]);
    $display("test set rate done");
    wr(motion_cmd_pkg::OFS_IRQ_MASK, 32'h3);
    // pass 1 masks everything so pass 2 stays quiet; pass 2 clears only the done bit
    foreach (rate[i]) begin
      cmd(8'h05 + 8'(i * 100));
      rd(motion_cmd_pkg::OFS_STATUS, 32'h301);
      repeat (2) @(posedge aclk);
      chk("irq", {31'h0, irq}, {31'h0, i != 2});
      wr(i == 1 ? motion_cmd_pkg::OFS_IRQ_MASK : motion_cmd_pkg::OFS_IRQ_STAT,
         i == 1 ? 32'h0 : 32'(3 - i));
    end
    rd(motion_cmd_pkg::OFS_IRQ_STAT, 32'h2, 32'h3);
    $display("test illegal code done");
    cmd(motion_cmd_pkg::CLEAR_PULSE_CODE);
    rd(motion_cmd_pkg::OFS_STATUS, 32'h2, 32'h3);
    chk("clear", {31'h0, clear_pulse_output}, 32'h1);
    wr(motion_cmd_pkg::OFS_NEW_POS, ~v);
    cmd(motion_cmd_pkg::LOAD_POSITION_CODE);
    wait_clear();
    rd(motion_cmd_pkg::OFS_STATUS, 32'h1);
    rd(motion_cmd_pkg::OFS_CUR_POS, v);
    cmd(motion_cmd_pkg::CLEAR_PULSE_CODE);
    wr(motion_cmd_pkg::OFS_CMD, 32'h200);
    rd(motion_cmd_pkg::OFS_STATUS, 32'h101, 32'hff03);
    wait_clear();
    $display("test clear pulse done");
    w = $random(seed);
    wr(motion_cmd_pkg::OFS_CFG_WORD, {8'h00, w[23:0] | 24'h1});
    wr(motion_cmd_pkg::OFS_CFG_PTR, 32'h0);
    for (int i = 0; i < 2; i++) begin
      cmd(motion_cmd_pkg::CONFIG_RELOAD_CODE);
      repeat (12) @(posedge aclk);
      rd(motion_cmd_pkg::OFS_STATUS, 32'h1);
      rd(motion_cmd_pkg::OFS_CFG_LIVE, 32'(1 - i));
    end
    $display("test config reload done");
    foreach (rate[i]) begin
      wr(motion_cmd_pkg::OFS_INHIBIT, {23'h0, 1'b1, 7'h0, i != 2});
      repeat (3) @(posedge aclk);
      chk("inhibit", {31'h0, drive_inhibit_output}, {31'h0, i != 2});
      rd(motion_cmd_pkg::OFS_INHIBIT, {31'h0, i != 2}, 32'h1);
    end
    rd(8'h3c, 32'h0, '1, motion_cmd_pkg::RESP_SLVERR);
    wr(8'h3c, 32'h1, motion_cmd_pkg::RESP_SLVERR);
    repeat (4) @(posedge aclk);
    $display("test inhibit and unmapped done");
    give_verdict();
  end
endmodule
